// ==== hdl/swm_batt_detect.sv ====
`timescale 1ns/1ps
// Battery interruption detector: a long drop followed by a restore.
module swm_batt_detect #(
    parameter int DROP_CYCLES = swm_pkg::DROP_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic i_below_drop,
    input wire logic i_above_restore,
    output logic o_event,
    output swm_pkg::swm_batt_e o_state
);
    localparam int CW = $clog2(DROP_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(DROP_CYCLES - 1);
    logic [CW-1:0] cnt_q; // Cycles spent below the drop level.

    // Drop timer and state; a disabled detector rests in idle.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_state <= swm_pkg::BAT_IDLE;
            cnt_q <= '0;
            o_event <= 1'b0;
        end else begin
            o_event <= 1'b0;
            if (!i_enable) begin
                o_state <= swm_pkg::BAT_IDLE;
                cnt_q <= '0;
            end else begin
                unique case (o_state)
                    swm_pkg::BAT_IDLE: begin
                        // The timer starts on any cycle that finds the level below the drop level.
                        cnt_q <= '0;
                        if (i_below_drop) begin
                            o_state <= swm_pkg::BAT_TIMING;
                        end
                    end
                    swm_pkg::BAT_TIMING: begin
                        if (!i_below_drop) begin
                            // A dip shorter than the drop time is forgotten.
                            o_state <= swm_pkg::BAT_IDLE;
                        end else if (cnt_q == LAST) begin
                            o_state <= swm_pkg::BAT_ARMED;
                        end else begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                    swm_pkg::BAT_ARMED: begin
                        // Only the higher restore level fires the event.
                        if (i_above_restore) begin
                            o_event <= 1'b1;
                            o_state <= swm_pkg::BAT_IDLE;
                        end
                    end
                    default: begin
                        o_state <= swm_pkg::BAT_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// ==== hdl/swm_pkg.sv ====
// Shared constants, types and register layout of the supply wake monitor.
package swm_pkg;
    // Register byte offsets on the Wishbone bus.
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_THRESH = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_EVENT = 8'h0c;
    localparam logic [7:0] ADR_MASK = 8'h10;
    localparam logic [7:0] ADR_PSMAP = 8'h14;
    // Control register fields.
    localparam int CTRL_LOWER_SEL = 0;
    localparam int CTRL_UPPER_SEL = 1;
    localparam int CTRL_BATT_DIS = 2;
    // Event register fields, also the clear bits on write.
    localparam int EVT_VOLT = 0;
    localparam int EVT_PWR_ON = 1;
    // Mask register field.
    localparam int MASK_VOLT = 0;
    // Status register fields.
    localparam int ST_REGION_LSB = 0;
    localparam int ST_ACTIVE = 2;
    localparam int ST_IN_WINDOW = 3;
    localparam int ST_VOLT = 4;
    localparam int ST_PWR_ON = 5;
    // Threshold register byte lanes.
    localparam int TH_LOW_LSB = 0;
    localparam int TH_CRIT_LSB = 8;
    localparam int TH_SUPER_LSB = 16;
    // Reset values.
    localparam logic [7:0] TH_LOW_RST = 8'h40;
    localparam logic [7:0] TH_CRIT_RST = 8'h60;
    localparam logic [7:0] TH_SUPER_RST = 8'hc0;
    localparam logic [7:0] PSMAP_RST = 8'he4;
    localparam logic UPPER_SEL_RST = 1'b0;
    localparam logic BATT_DIS_RST = 1'b1;
    localparam logic MASK_VOLT_RST = 1'b0;
    // Fixed hysteresis of each threshold, in threshold code steps.
    localparam logic [7:0] HYS_LOW = 8'h04;
    localparam logic [7:0] HYS_CRIT = 8'h04;
    localparam logic [7:0] HYS_SUPER = 8'h04;
    // Timing: clock rate and the delays in their own units.
    localparam int CLK_MHZ = 20;
    localparam int DROP_TIME_US = 100;
    localparam int HOLD_DELAY_US = 1000;
    localparam int DROP_CYCLES = DROP_TIME_US * CLK_MHZ;
    localparam int HOLD_CYCLES = HOLD_DELAY_US * CLK_MHZ;
    // Cycles the strap needs to pass the synchroniser.
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    // Supply power regions, also the index into the pin map.
    typedef enum logic [1:0] {
        REG_NORMAL = 2'b00,
        REG_CRIT = 2'b01,
        REG_LOW = 2'b10,
        REG_SUPER = 2'b11
    } swm_region_e;
    // Operating mode.
    typedef enum logic {
        MODE_SLEEP = 1'b0,
        MODE_ACTIVE = 1'b1
    } swm_mode_e;
    // Battery drop detector states.
    typedef enum logic [1:0] {
        BAT_IDLE = 2'b00,
        BAT_TIMING = 2'b01,
        BAT_ARMED = 2'b10
    } swm_batt_e;
    // Supply comparator results, high when the supply is above.
    typedef struct packed {
        logic above_super;
        logic above_crit;
        logic above_low;
    } swm_cmp_s;
    // Threshold codes driven to the analog comparators.
    typedef struct packed {
        logic [7:0] super_th;
        logic [7:0] crit_th;
        logic [7:0] low_th;
    } swm_th_s;
endpackage

// ==== hdl/swm_sync.sv ====
`timescale 1ns/1ps
// Two flip-flop synchroniser for a vector of independent levels.
module swm_sync #(
    parameter int WIDTH = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q; // First stage, read only by the second.

    // Both stages clear to zero and then follow the inputs.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// ==== hdl/swm_top.sv ====
`timescale 1ns/1ps
module swm_top #(
    parameter int DROP_CYCLES = swm_pkg::DROP_CYCLES,
    parameter int HOLD_CYCLES = swm_pkg::HOLD_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire swm_pkg::swm_cmp_s i_cmp,
    input wire logic i_batt_below_drop,
    input wire logic i_batt_above_restore,
    input wire logic i_wake_high_strap,
    input wire logic i_power_hold_in_n,
    input wire logic i_activity,
    output swm_pkg::swm_th_s o_th,
    output logic o_power_state_hi_pin,
    output logic o_power_state_lo_pin,
    output logic o_int_n,
    output logic o_active
);
    localparam int HW = $clog2(HOLD_CYCLES + 1);
    localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);

    // Returns the threshold lowered by its hysteresis while above it.
    function automatic logic [7:0] hys_th(
        input logic [7:0] th,
        input logic [7:0] hys,
        input logic above
    );
        logic [7:0] r;
        r = th;
        if (above) begin
            r = (th > hys) ? (th - hys) : 8'h00;
        end
        return r;
    endfunction

    // Looks up the two-pin code of a region in the pin map table.
    function automatic logic [1:0] ps_code(
        input logic [7:0] map,
        input swm_pkg::swm_region_e reg_sel
    );
        logic [1:0] r;
        r = 2'b00;
        unique case (reg_sel)
            swm_pkg::REG_NORMAL: r = map[1:0];
            swm_pkg::REG_CRIT: r = map[3:2];
            swm_pkg::REG_LOW: r = map[5:4];
            swm_pkg::REG_SUPER: r = map[7:6];
        endcase
        return r;
    endfunction

    logic [7:0] async_in; // Raw outside levels.
    logic [7:0] sync_in; // The same levels after two flops.
    swm_pkg::swm_cmp_s cmp_s; // Synchronised supply comparators.
    logic below_drop_s; // Synchronised battery drop level.
    logic above_restore_s; // Synchronised battery restore level.
    logic strap_s; // Synchronised wake strap.
    logic hold_n_s; // Synchronised hold input, low holds active.
    logic activity_s; // Synchronised qualified activity.

    logic lower_sel_q; // Lower wake bound select.
    logic upper_sel_q; // Upper wake bound select.
    logic batt_dis_q; // Battery detection disable.
    logic [1:0] strap_cnt_q; // Wait for the strap to settle.
    logic [7:0] th_low_q; // Low threshold code.
    logic [7:0] th_crit_q; // Critical threshold code.
    logic [7:0] th_super_q; // Super threshold code.
    logic [7:0] psmap_q; // Region to pin code table.
    logic mask_volt_q; // Voltage event mask.
    logic volt_flag_q; // Voltage event flag.
    logic po_flag_q; // Power-on event flag.
    logic pu_pend_q; // Power-up not yet seen by the detector.
    swm_pkg::swm_mode_e mode_q; // Operating mode.
    logic [HW-1:0] hold_cnt_q; // Hold release delay counter.
    swm_pkg::swm_region_e region_q; // Region shown in status.
    swm_pkg::swm_region_e region_now; // Region decoded this cycle.
    logic in_window; // Supply inside the allowed wake window.
    logic batt_evt; // One-cycle battery interruption pulse.
    swm_pkg::swm_batt_e batt_state; // Detector state.
    logic pu_evt; // Power-up counted as battery event.
    logic any_batt; // Either kind of battery event.
    logic bus_req; // Bus request at the acking edge.
    logic wr_en; // Write takes effect this edge.
    logic [31:0] rdata; // Read data before the output flop.
    logic [31:0] status_word; // Status register image.
    logic clr_v; // Software clear of the voltage flag.
    logic clr_p; // Software clear of the power-on flag.

    assign async_in = {i_cmp, i_batt_below_drop, i_batt_above_restore,
                       i_wake_high_strap, i_power_hold_in_n, i_activity};

    // All outside levels are brought into the clock domain first.
    swm_sync #(
        .WIDTH(8)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_async(async_in),
        .o_sync(sync_in)
    );

    assign cmp_s = sync_in[7:5];
    assign below_drop_s = sync_in[4];
    assign above_restore_s = sync_in[3];
    assign strap_s = sync_in[2];
    assign hold_n_s = sync_in[1];
    assign activity_s = sync_in[0];

    assign bus_req = i_wb_cyc && i_wb_stb && o_wb_ack;
    assign wr_en = bus_req && i_wb_we;

    // Region decode from the synchronised comparators.
    always_comb begin
        if (cmp_s.above_super) begin
            region_now = swm_pkg::REG_SUPER;
        end else if (cmp_s.above_crit) begin
            region_now = swm_pkg::REG_NORMAL;
        end else if (cmp_s.above_low) begin
            region_now = swm_pkg::REG_CRIT;
        end else begin
            region_now = swm_pkg::REG_LOW;
        end
    end

    // Wake window from the two select bits.
    always_comb begin
        logic lo_ok;
        logic hi_ok;
        lo_ok = lower_sel_q ? cmp_s.above_crit : cmp_s.above_low;
        hi_ok = upper_sel_q || !cmp_s.above_super;
        in_window = lo_ok && hi_ok;
    end

    // Control bits; the lower select default comes from the strap.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            lower_sel_q <= 1'b0;
            upper_sel_q <= swm_pkg::UPPER_SEL_RST;
            batt_dis_q <= swm_pkg::BATT_DIS_RST;
            strap_cnt_q <= 2'h0;
        end else if (strap_cnt_q != swm_pkg::STRAP_WAIT) begin
            // The strap is caught once, after it has crossed the sync.
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == swm_pkg::STRAP_WAIT - 2'h1) begin
                lower_sel_q <= strap_s;
            end
        end else if (wr_en && i_wb_adr == swm_pkg::ADR_CTRL && i_wb_sel[0]) begin
            lower_sel_q <= i_wb_dat[swm_pkg::CTRL_LOWER_SEL];
            upper_sel_q <= i_wb_dat[swm_pkg::CTRL_UPPER_SEL];
            batt_dis_q <= i_wb_dat[swm_pkg::CTRL_BATT_DIS];
        end
    end

    // Threshold register, one byte lane per threshold.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            th_low_q <= swm_pkg::TH_LOW_RST;
            th_crit_q <= swm_pkg::TH_CRIT_RST;
            th_super_q <= swm_pkg::TH_SUPER_RST;
        end else if (wr_en && i_wb_adr == swm_pkg::ADR_THRESH) begin
            if (i_wb_sel[0]) begin
                th_low_q <= i_wb_dat[swm_pkg::TH_LOW_LSB +: 8];
            end
            if (i_wb_sel[1]) begin
                th_crit_q <= i_wb_dat[swm_pkg::TH_CRIT_LSB +: 8];
            end
            if (i_wb_sel[2]) begin
                th_super_q <= i_wb_dat[swm_pkg::TH_SUPER_LSB +: 8];
            end
        end
    end

    // Pin map table and mask register.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            psmap_q <= swm_pkg::PSMAP_RST;
            mask_volt_q <= swm_pkg::MASK_VOLT_RST;
        end else begin
            if (wr_en && i_wb_adr == swm_pkg::ADR_PSMAP && i_wb_sel[0]) begin
                psmap_q <= i_wb_dat[7:0];
            end
            if (wr_en && i_wb_adr == swm_pkg::ADR_MASK && i_wb_sel[0]) begin
                mask_volt_q <= i_wb_dat[swm_pkg::MASK_VOLT];
            end
        end
    end

    // Threshold codes to the comparators, shifted down while above.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_th <= '0;
        end else begin
            o_th.low_th <= hys_th(th_low_q, swm_pkg::HYS_LOW, cmp_s.above_low);
            o_th.crit_th <= hys_th(th_crit_q, swm_pkg::HYS_CRIT, cmp_s.above_crit);
            o_th.super_th <= hys_th(th_super_q, swm_pkg::HYS_SUPER,
                                    cmp_s.above_super);
        end
    end

    // Battery interruption detector.
    swm_batt_detect #(
        .DROP_CYCLES(DROP_CYCLES)
    ) u_batt (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_enable(!batt_dis_q),
        .i_below_drop(below_drop_s),
        .i_above_restore(above_restore_s),
        .o_event(batt_evt),
        .o_state(batt_state)
    );

    // Power-up is presented once to an enabled detector.
    assign pu_evt = pu_pend_q && !batt_dis_q;
    assign any_batt = batt_evt || pu_evt;

    // Pending power-up marker, spent on first enabled cycle.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pu_pend_q <= 1'b1;
        end else if (pu_evt) begin
            pu_pend_q <= 1'b0;
        end
    end

    // Mode machine with the hold release delay.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_q <= swm_pkg::MODE_ACTIVE;
            hold_cnt_q <= '0;
        end else begin
            unique case (mode_q)
                swm_pkg::MODE_ACTIVE: begin
                    if (!hold_n_s || (activity_s && region_now != swm_pkg::REG_LOW)) begin
                        // Held, or kept up by activity outside the low region.
                        hold_cnt_q <= '0;
                    end else if (region_now == swm_pkg::REG_LOW) begin
                        mode_q <= swm_pkg::MODE_SLEEP;
                        hold_cnt_q <= '0;
                    end else if (hold_cnt_q == HOLD_LAST) begin
                        mode_q <= swm_pkg::MODE_SLEEP;
                        hold_cnt_q <= '0;
                    end else begin
                        hold_cnt_q <= hold_cnt_q + 1'b1;
                    end
                end
                swm_pkg::MODE_SLEEP: begin
                    hold_cnt_q <= '0;
                    // Any wake source still needs the supply in the window.
                    if (in_window && (activity_s || any_batt)) begin
                        mode_q <= swm_pkg::MODE_ACTIVE;
                    end
                end
            endcase
        end
    end

    // Region status and the power-state pins.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            region_q <= swm_pkg::REG_NORMAL;
            o_power_state_hi_pin <= 1'b0;
            o_power_state_lo_pin <= 1'b0;
        end else if (mode_q == swm_pkg::MODE_ACTIVE || any_batt) begin
            region_q <= region_now;
            {o_power_state_hi_pin, o_power_state_lo_pin}
                <= ps_code(psmap_q, region_now);
        end
    end

    // Write-one-to-clear strobes of the two event flags.
    assign clr_v = wr_en && i_wb_adr == swm_pkg::ADR_EVENT && i_wb_sel[0]
                   && i_wb_dat[swm_pkg::EVT_VOLT];
    assign clr_p = wr_en && i_wb_adr == swm_pkg::ADR_EVENT && i_wb_sel[0]
                   && i_wb_dat[swm_pkg::EVT_PWR_ON];

    // Event flags: hardware set wins over a software clear.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            volt_flag_q <= 1'b0;
            po_flag_q <= 1'b1;
        end else begin
            if (mode_q == swm_pkg::MODE_ACTIVE && region_now != region_q) begin
                volt_flag_q <= 1'b1;
            end else if (clr_v) begin
                volt_flag_q <= 1'b0;
            end
            if (any_batt) begin
                po_flag_q <= 1'b1;
            end else if (clr_p) begin
                po_flag_q <= 1'b0;
            end
        end
    end

    // Active-low interrupt from the flags.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_int_n <= 1'b1;
        end else begin
            o_int_n <= !((volt_flag_q && !mask_volt_q) || po_flag_q);
        end
    end

    // Mode seen from outside.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_active <= 1'b0;
        end else begin
            o_active <= (mode_q == swm_pkg::MODE_ACTIVE);
        end
    end

    // Status image.
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[swm_pkg::ST_REGION_LSB +: 2] = region_q;
        status_word[swm_pkg::ST_ACTIVE] = (mode_q == swm_pkg::MODE_ACTIVE);
        status_word[swm_pkg::ST_IN_WINDOW] = in_window;
        status_word[swm_pkg::ST_VOLT] = volt_flag_q;
        status_word[swm_pkg::ST_PWR_ON] = po_flag_q;
    end

    // Read mux; unmapped addresses read as zero.
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (i_wb_adr)
            swm_pkg::ADR_CTRL: begin
                rdata[swm_pkg::CTRL_LOWER_SEL] = lower_sel_q;
                rdata[swm_pkg::CTRL_UPPER_SEL] = upper_sel_q;
                rdata[swm_pkg::CTRL_BATT_DIS] = batt_dis_q;
            end
            swm_pkg::ADR_THRESH: begin
                rdata[23:0] = {th_super_q, th_crit_q, th_low_q};
            end
            swm_pkg::ADR_STATUS: begin
                rdata = status_word;
            end
            swm_pkg::ADR_EVENT: begin
                rdata[swm_pkg::EVT_VOLT] = volt_flag_q;
                rdata[swm_pkg::EVT_PWR_ON] = po_flag_q;
            end
            swm_pkg::ADR_MASK: begin
                rdata[swm_pkg::MASK_VOLT] = mask_volt_q;
            end
            swm_pkg::ADR_PSMAP: begin
                rdata[7:0] = psmap_q;
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

    // Wishbone answer: ack one cycle after the request, for one cycle.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
            if (i_wb_cyc && i_wb_stb && !o_wb_ack) begin
                o_wb_dat <= rdata;
            end
        end
    end
endmodule

// ==== testbench/swm_afe_model.sv ====
`timescale 1ns/1ps
// Comparator front end that faces the monitor: supply and battery trip points.
module swm_afe_model #(
    parameter logic [7:0] DROP_LVL = 8'h40,
    parameter logic [7:0] RESTORE_LVL = 8'hc0
) (
    input wire logic [7:0] i_supply,
    input wire logic [7:0] i_batt,
    input wire swm_pkg::swm_th_s i_th,
    output swm_pkg::swm_cmp_s o_cmp,
    output logic o_below_drop,
    output logic o_above_restore
);
    // A supply sitting exactly on a threshold code counts as above it.
    assign o_cmp.above_low = i_supply >= i_th.low_th;
    assign o_cmp.above_crit = i_supply >= i_th.crit_th;
    assign o_cmp.above_super = i_supply >= i_th.super_th;
    // Drop and restore are separate trip points, so a mid level shows neither.
    assign o_below_drop = i_batt < DROP_LVL;
    assign o_above_restore = i_batt > RESTORE_LVL;
endmodule

// ==== testbench/swm_top_sva.sv ====
`timescale 1ns/1ps
// Pin-level checker for the supply wake monitor.
module swm_top_sva (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire swm_pkg::swm_cmp_s i_cmp,
    input wire logic i_power_hold_in_n,
    input wire swm_pkg::swm_th_s o_th,
    input wire logic o_int_n,
    input wire logic o_active
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // Low region with the hold input released for four cycles.
    sequence s_low_free;
        (o_active && i_power_hold_in_n && !i_cmp.above_low)[*4];
    endsequence
    // Supply newly above the low trip point while the bus stays quiet.
    sequence s_low_rise;
        $rose(i_cmp.above_low) ##1 (i_cmp.above_low && !i_wb_cyc)[*4];
    endsequence
    chk_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("request not answered in one cycle");
    chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    chk_hole_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 8'h18
        |-> o_wb_dat == 32'h0) else $error("unmapped read not zero");
    chk_hys_low: assert property (s_low_rise
        |-> o_th.low_th == $past(o_th.low_th, 4) - swm_pkg::HYS_LOW) else $error("no hysteresis");
    chk_wake_window: assert property ($rose(o_active) |-> $past(i_cmp.above_low, 2)
        || $past(i_cmp.above_low, 3) || $past(i_cmp.above_low, 4)) else $error("woke too low");
    chk_low_sleep: assert property (s_low_free |-> ##[0:3] !o_active)
        else $error("no quick sleep in low region");
    chk_reset_idle: assert property (disable iff (1'b0) i_rst ##1 i_rst
        |-> !o_active && o_int_n) else $error("outputs not idle in reset");
    chk_po_int: assert property ($fell(i_rst) |-> ##[1:2] !o_int_n)
        else $error("no interrupt after power-up");
endmodule

bind swm_top swm_top_sva u_sva (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we,
    .i_wb_adr, .o_wb_dat, .o_wb_ack, .i_cmp, .i_power_hold_in_n, .o_th, .o_int_n, .o_active);

// ==== testbench/swm_top_tb.sv ====
`timescale 1ns/1ps
// Self-checking bench for the supply wake monitor.
module swm_top_tb;
    logic clk = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0, hold_n = 1'b0, actv = 1'b0;
    logic [7:0] adr = 8'h00, supply = 8'h80, batt = 8'hf0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic ack, hi, lo, int_n, act, below, restore, strap = 1'b1;
    swm_pkg::swm_cmp_s cmp;
    swm_pkg::swm_th_s th;
    int miscompares = 0, checks = 0, cycles = 0;
    logic [7:0] lv [4] = '{8'h50, 8'h30, 8'hd0, 8'h80};
    logic [1:0] ps [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
    logic [7:0] st [4] = '{8'h15, 8'h16, 8'h17, 8'h1c};
    initial forever #25 clk = ~clk;
    swm_top #(.DROP_CYCLES(8), .HOLD_CYCLES(16)) dut (.i_ref_clk(clk), .i_rst(rst),
        .i_wb_cyc(req), .i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
        .i_wb_sel(4'hf), .o_wb_dat(rdat), .o_wb_ack(ack), .i_cmp(cmp),
        .i_batt_below_drop(below), .i_batt_above_restore(restore), .i_wake_high_strap(strap),
        .i_power_hold_in_n(hold_n), .i_activity(actv), .o_th(th), .o_power_state_hi_pin(hi),
        .o_power_state_lo_pin(lo), .o_int_n(int_n), .o_active(act));
    swm_afe_model afe (.i_supply(supply), .i_batt(batt), .i_th(th), .o_cmp(cmp),
        .o_below_drop(below), .o_above_restore(restore));
    // Counts a compare and reports a difference at once.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One classic bus cycle, held until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        req <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // Moves the supply or the battery and lets the synchronisers settle.
    task automatic lvl(input logic [7:0] s);
        @(posedge clk);
        supply <= s;
        repeat (8) @(posedge clk);
    endtask
    task automatic bat(input logic [7:0] v, input int n);
        @(posedge clk);
        batt <= v;
        repeat (n) @(posedge clk);
    endtask
    task automatic final_report();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        wb(1'b1, swm_pkg::ADR_EVENT, 32'h1);
        rd(swm_pkg::ADR_CTRL, 32'h5);
        rd(swm_pkg::ADR_THRESH, 32'h00c06040);
        rd(swm_pkg::ADR_STATUS, 32'h2c);
        rd(swm_pkg::ADR_EVENT, 32'h2);
        rd(swm_pkg::ADR_PSMAP, 32'he4);
        rd(swm_pkg::ADR_MASK, 32'h0);
        rd(8'h18, 32'h0);
        wb(1'b1, swm_pkg::ADR_EVENT, 32'h3);
        $display("reset test done");
        wb(1'b1, swm_pkg::ADR_PSMAP, 32'h1b);
        foreach (lv[i]) begin
            lvl(lv[i]);
            chk({hi, lo}, ps[i]);
            rd(swm_pkg::ADR_STATUS, st[i]);
            chk(int_n, 1'b0);
            wb(1'b1, swm_pkg::ADR_EVENT, 32'h1);
        end
        lvl(8'h5e);
        rd(swm_pkg::ADR_EVENT, 32'h0);
        wb(1'b1, swm_pkg::ADR_MASK, 32'h1);
        lvl(8'h50);
        chk(int_n, 1'b1);
        lvl(8'h80);
        wb(1'b1, swm_pkg::ADR_EVENT, 32'h1);
        wb(1'b1, swm_pkg::ADR_MASK, 32'h0);
        $display("region test done");
        wb(1'b1, swm_pkg::ADR_CTRL, 32'h0);
        rd(swm_pkg::ADR_EVENT, 32'h2);
        wb(1'b1, swm_pkg::ADR_EVENT, 32'h2);
        bat(8'h20, 4);
        bat(8'hf0, 8);
        rd(swm_pkg::ADR_EVENT, 32'h0);
        bat(8'h20, 12);
        bat(8'h80, 8);
        rd(swm_pkg::ADR_EVENT, 32'h0);
        bat(8'hf0, 8);
        rd(swm_pkg::ADR_EVENT, 32'h2);
        chk(int_n, 1'b0);
        wb(1'b1, swm_pkg::ADR_EVENT, 32'h2);
        $display("battery test done");
        hold_n <= 1'b1;
        lvl(8'h30);
        chk(act, 1'b0);
        actv <= 1'b1;
        lvl(8'hd0);
        chk(act, 1'b0);
        wb(1'b1, swm_pkg::ADR_CTRL, 32'h2);
        repeat (8) @(posedge clk);
        chk(act, 1'b1);
        lvl(8'h30);
        wb(1'b1, swm_pkg::ADR_CTRL, 32'h1);
        lvl(8'h50);
        chk(act, 1'b0);
        lvl(8'h80);
        chk(act, 1'b1);
        actv <= 1'b0;
        lvl(8'h80);
        chk(act, 1'b1);
        repeat (16) @(posedge clk);
        chk(act, 1'b0);
        lvl(8'h50);
        bat(8'h20, 12);
        bat(8'hf0, 8);
        chk(act, 1'b0);
        lvl(8'h80);
        bat(8'h20, 12);
        bat(8'hf0, 8);
        chk(act, 1'b1);
        $display("wake test done");
        final_report();
    end
endmodule
